// ---- rtl/dtc_defines.svh ----
// Purpose: Constants for the dual timer/counter block
// Assumes: Included by its bare name from the prescaler and top design files
// Notes:   Definitions only
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH

// Timer mode register fields, per 4-bit nibble (A low nibble, B high nibble)
`define DTC_MODE_LO_BIT     0
`define DTC_MODE_HI_BIT     1
`define DTC_CT_BIT          2
`define DTC_GATE_BIT        3
`define DTC_NIBBLE_B        4
`define DTC_MODE_RST        8'h00

// Count register select codes for software writes
`define DTC_SEL_LOW_A       2'h0
`define DTC_SEL_HIGH_A      2'h1
`define DTC_SEL_LOW_B       2'h2
`define DTC_SEL_HIGH_B      2'h3

// Machine-cycle prescaler terminal counts
`define DTC_DIV12_LAST      4'hb
`define DTC_DIV6_LAST       4'h5

// Interrupt vectors
`define DTC_VEC_A           16'h000b
`define DTC_VEC_B           16'h001b
`define DTC_VEC_NONE        16'h0000

`endif

// ---- rtl/dtc_pkg.sv ----
// Purpose: Types for the dual timer/counter block
// Assumes: Nothing beyond the defines header
// Notes:   Mode codes follow the two mode select bits
`default_nettype none
package dtc_pkg;

	typedef enum logic [1:0] {
		DTC_M13    = 2'b00,
		DTC_M16    = 2'b01,
		DTC_RELOAD = 2'b10,
		DTC_SPLIT  = 2'b11
	} dtc_mode_t;

	typedef struct packed {
		logic      gate;
		logic      ct;
		dtc_mode_t mode;
	} dtc_cfg_t;

	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} dtc_count_t;

endpackage : dtc_pkg

`default_nettype wire

// ---- rtl/dtc_presc.sv ----
// Purpose: Machine-cycle tick generator
// Assumes: MCLK is the system clock
// Notes:   Divides by 12 or by 6; one-cycle tick
`timescale 1ns/1ps
`include "dtc_defines.svh"
`default_nettype none

module dtc_presc (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// Control
	input  wire logic six_clk_mode,
	// Tick
	output logic      tick
);

	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic [3:0] last;
	logic       tick_q;
	logic       tick_d;

	always_comb begin
		last   = six_clk_mode ? `DTC_DIV6_LAST : `DTC_DIV12_LAST;
		tick_d = (cnt_q >= last);
		cnt_d  = tick_d ? 4'h0 : cnt_q + 4'h1;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cnt_q  <= 4'h0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;

endmodule : dtc_presc

`default_nettype wire

// ---- rtl/dtc_top.sv ----
// Purpose: Two timer/counters with 13-bit, 16-bit, reload and split modes
// Assumes: All inputs synchronous to MCLK; software strobes are one cycle
// Notes:   Software count writes win over counting in the same cycle
`timescale 1ns/1ps
`include "dtc_defines.svh"
`default_nettype none

module dtc_top
	import dtc_pkg::*;
(
	// Clock and reset
	input  wire logic        MCLK,
	input  wire logic        RST_B,
	// Core configuration
	input  wire logic        SIX_CLK_MODE,
	// Timer mode register write
	input  wire logic        MODE_WE,
	input  wire logic [7:0]  MODE_WDATA,
	// Run bits from the control register
	input  wire logic        RUN_BIT_A,
	input  wire logic        RUN_BIT_B,
	// Count register writes
	input  wire logic        CNT_WE,
	input  wire logic [1:0]  CNT_SEL,
	input  wire logic [7:0]  CNT_WDATA,
	// Flag clear and interrupt acknowledge
	input  wire logic        FLAG_CLR_A,
	input  wire logic        FLAG_CLR_B,
	input  wire logic        IRQ_ACK,
	// Interrupt enables
	input  wire logic        OVERFLOW_IRQ_EN_A,
	input  wire logic        OVERFLOW_IRQ_EN_B,
	input  wire logic        GLOBAL_IRQ_ENABLE,
	// Pins
	input  wire logic        EXT_IRQ_PIN_A,
	input  wire logic        EXT_IRQ_PIN_B,
	input  wire logic        CNT_PIN_A,
	input  wire logic        CNT_PIN_B,
	// State
	output logic [7:0]       TIMER_MODE_REG,
	output logic [7:0]       COUNT_LOW_A,
	output logic [7:0]       COUNT_HIGH_A,
	output logic [7:0]       COUNT_LOW_B,
	output logic [7:0]       COUNT_HIGH_B,
	output logic             OVERFLOW_FLAG_A,
	output logic             OVERFLOW_FLAG_B,
	// Interrupt request
	output logic             IRQ_REQ,
	output logic [15:0]      IRQ_VEC
);

	logic [7:0]  mode_q;
	logic [7:0]  mode_d;
	dtc_count_t  cnt_q   [2];
	dtc_count_t  cnt_d   [2];
	logic [1:0]  pin_q;
	logic [1:0]  flag_q;
	logic [1:0]  flag_d;
	logic        req_q;
	logic        req_d;
	logic [15:0] vec_q;
	logic [15:0] vec_d;
	logic        tick;
	dtc_cfg_t    cfg     [2];
	logic [1:0]  inc;
	logic [1:0]  cnt_pin;
	logic [1:0]  ext_pin;
	logic [1:0]  run;
	logic [16:0] res_a;
	logic [16:0] res_b;
	logic [8:0]  split_hi;
	logic        split_a;
	logic        ack_a;
	logic        ack_b;

	dtc_presc u_presc (
		.clk          (MCLK),
		.rst_b        (RST_B),
		.six_clk_mode (SIX_CLK_MODE),
		.tick         (tick)
	);

	// Returns {overflow, high, low} after one increment
	function automatic logic [16:0] step(input dtc_mode_t m, input dtc_count_t c);
		logic [12:0] v13;
		logic [16:0] r;
		v13 = {c.high, c.low[4:0]};
		r   = {1'b0, c.high, c.low};
		unique case (m)
			// 13-bit wrap; low bits 7..5 kept untouched
			DTC_M13: begin
				v13 = v13 + 13'h0001;
				r   = {(v13 == 13'h0000), v13[12:5], c.low[7:5], v13[4:0]};
			end
			DTC_M16: begin
				r = {1'b0, c.high, c.low} + 17'h00001;
			end
			// reload low from high, high unchanged
			DTC_RELOAD: begin
				if (c.low == 8'hff) begin
					r = {1'b1, c.high, c.high};
				end else begin
					r = {1'b0, c.high, c.low + 8'h01};
				end
			end
			// split code holds here; timer A split is handled outside
			DTC_SPLIT: begin
				r = {1'b0, c.high, c.low};
			end
		endcase
		return r;
	endfunction : step

	assign cnt_pin = {CNT_PIN_B, CNT_PIN_A};
	assign ext_pin = {EXT_IRQ_PIN_B, EXT_IRQ_PIN_A};
	assign run     = {RUN_BIT_B, RUN_BIT_A};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_src
			// each nibble of the mode register configures one timer
			assign cfg[gi] = dtc_cfg_t'(mode_q[gi*`DTC_NIBBLE_B +: 4]);
			// run and gate qualify counting; clock or falling pin edge
			assign inc[gi] = run[gi] && (!cfg[gi].gate || ext_pin[gi])
				&& (cfg[gi].ct ? (pin_q[gi] && !cnt_pin[gi]) : tick);
		end
	endgenerate

	assign split_a = (cfg[0].mode == DTC_SPLIT);
	assign res_a   = step(cfg[0].mode, cnt_q[0]);
	assign res_b   = step(cfg[1].mode, cnt_q[1]);
	assign ack_a   = IRQ_ACK && (vec_q == `DTC_VEC_A);
	assign ack_b   = IRQ_ACK && (vec_q == `DTC_VEC_B);

	// Count and flag next state
	always_comb begin
		mode_d   = MODE_WE ? MODE_WDATA : mode_q;
		cnt_d[0] = cnt_q[0];
		cnt_d[1] = cnt_q[1];
		flag_d   = flag_q;
		split_hi = {1'b0, cnt_q[0].high} + 9'h001;
		// vectoring clears the flag; clear by software too
		if (FLAG_CLR_A || ack_a) begin
			flag_d[0] = 1'b0;
		end
		if (FLAG_CLR_B || ack_b) begin
			flag_d[1] = 1'b0;
		end
		if (split_a) begin
			// low byte on A's own controls and flag
			if (inc[0]) begin
				cnt_d[0].low = cnt_q[0].low + 8'h01;
				if (cnt_q[0].low == 8'hff) begin
					flag_d[0] = 1'b1;
				end
			end
			// high byte on machine cycles under B's run bit, flags B
			if (RUN_BIT_B && tick) begin
				cnt_d[0].high = split_hi[7:0];
				if (split_hi[8]) begin
					flag_d[1] = 1'b1;
				end
			end
		end else if (inc[0]) begin
			// 06h gives event counting in reload mode through the generic path
			cnt_d[0] = dtc_count_t'(res_a[15:0]);
			if (res_a[16]) begin
				flag_d[0] = 1'b1;
			end
		end
		// B's split code freezes it; B still counts but no flag while A split
		if (inc[1] && cfg[1].mode != DTC_SPLIT) begin
			cnt_d[1] = dtc_count_t'(res_b[15:0]);
			if (res_b[16] && !split_a) begin
				flag_d[1] = 1'b1;
			end
		end
		// run bit never touches counts; besides the reload mode, only software writes load them
		if (CNT_WE) begin
			unique case (CNT_SEL)
				`DTC_SEL_LOW_A:  cnt_d[0].low  = CNT_WDATA;
				`DTC_SEL_HIGH_A: cnt_d[0].high = CNT_WDATA;
				`DTC_SEL_LOW_B:  cnt_d[1].low  = CNT_WDATA;
				`DTC_SEL_HIGH_B: cnt_d[1].high = CNT_WDATA;
			endcase
		end
	end

	// request needs individual and global enable; A has priority
	always_comb begin
		req_d = 1'b0;
		vec_d = `DTC_VEC_NONE;
		if (GLOBAL_IRQ_ENABLE && OVERFLOW_IRQ_EN_A && flag_d[0]) begin
			req_d = 1'b1;
			vec_d = `DTC_VEC_A;
		end else if (GLOBAL_IRQ_ENABLE && OVERFLOW_IRQ_EN_B && flag_d[1]) begin
			req_d = 1'b1;
			vec_d = `DTC_VEC_B;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			mode_q <= `DTC_MODE_RST;
			cnt_q  <= '{default: '0};
			pin_q  <= 2'h3;
			flag_q <= 2'h0;
			req_q  <= 1'b0;
			vec_q  <= `DTC_VEC_NONE;
		end else begin
			mode_q <= mode_d;
			cnt_q  <= cnt_d;
			pin_q  <= cnt_pin;
			flag_q <= flag_d;
			req_q  <= req_d;
			vec_q  <= vec_d;
		end
	end

	assign TIMER_MODE_REG  = mode_q;
	assign COUNT_LOW_A     = cnt_q[0].low;
	assign COUNT_HIGH_A    = cnt_q[0].high;
	assign COUNT_LOW_B     = cnt_q[1].low;
	assign COUNT_HIGH_B    = cnt_q[1].high;
	assign OVERFLOW_FLAG_A = flag_q[0];
	assign OVERFLOW_FLAG_B = flag_q[1];
	assign IRQ_REQ         = req_q;
	assign IRQ_VEC         = vec_q;

endmodule : dtc_top

`default_nettype wire

// ---- tb/dtc_assertions.sv ----
// Purpose: Port checks for dtc_top
// Assumes: Bound onto dtc_top
// Notes:   Watches timer B, flag A and interrupt ports
`timescale 1ns/1ps
`default_nettype none
module dtc_assertions (
	// Clock and reset
	input wire logic	MCLK,
	input wire logic	RST_B,
	// Controls
	input wire logic	MODE_WE,
	input wire logic [7:0]	MODE_WDATA,
	input wire logic	RUN_BIT_A,
	input wire logic	RUN_BIT_B,
	input wire logic	CNT_WE,
	input wire logic	IRQ_ACK,
	input wire logic	OVERFLOW_IRQ_EN_A,
	input wire logic	GLOBAL_IRQ_ENABLE,
	// State
	input wire logic [7:0]	TIMER_MODE_REG,
	input wire logic [7:0]	COUNT_LOW_B,
	input wire logic [7:0]	COUNT_HIGH_B,
	input wire logic	OVERFLOW_FLAG_A,
	input wire logic	OVERFLOW_FLAG_B,
	input wire logic	IRQ_REQ,
	input wire logic [15:0]	IRQ_VEC
);
	logic [15:0]	cb;
	logic [1:0]	mb;
	logic	sp;
	assign cb = {COUNT_HIGH_B, COUNT_LOW_B};
	assign mb = TIMER_MODE_REG[5:4];
	// Split A steals B's flag, so B wrap checks exclude it
	assign sp = TIMER_MODE_REG[1:0] == 2'h3;
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_B);
	a_mode_write: assert property (MODE_WE |=> TIMER_MODE_REG == $past(MODE_WDATA))
		else $error("mode readback wrong");
	a_b_frozen: assert property (mb == 2'h3 && !CNT_WE |=> $stable(cb))
		else $error("B moved in mode 3");
	a_run_keeps: assert property ($rose(RUN_BIT_B) && mb == 2'h1 && !CNT_WE
		|=> 16'(cb - $past(cb)) <= 16'h1)
		else $error("run start altered count");
	a_m16_wrap: assert property ((mb == 2'h1 && !sp && !CNT_WE && cb == 16'hffff)
		##1 cb == 16'h0 |-> OVERFLOW_FLAG_B)
		else $error("no flag on 16-bit wrap");
	a_m13_wrap: assert property ((mb == 2'h0 && !sp && !CNT_WE
		&& {cb[15:8], cb[4:0]} == 13'h1fff)
		##1 {cb[15:8], cb[4:0]} == 13'h0 |-> OVERFLOW_FLAG_B)
		else $error("no flag on 13-bit wrap");
	a_vec_a_cause: assert property (IRQ_VEC == 16'h000b |-> OVERFLOW_FLAG_A && IRQ_REQ
		&& $past(OVERFLOW_IRQ_EN_A) && $past(GLOBAL_IRQ_ENABLE))
		else $error("vector A without cause");
	a_no_global: assert property (!$past(GLOBAL_IRQ_ENABLE) |-> !IRQ_REQ)
		else $error("request with global off");
	a_ack_clears: assert property (IRQ_ACK && IRQ_VEC == 16'h000b && !RUN_BIT_A
		|=> !OVERFLOW_FLAG_A)
		else $error("ack left flag A");
	c_irq_a: cover property (IRQ_REQ && IRQ_VEC == 16'h000b);
	c_flag_b: cover property ($rose(OVERFLOW_FLAG_B));
	c_split: cover property (sp && RUN_BIT_A);
endmodule : dtc_assertions
bind dtc_top dtc_assertions i_dtc_assertions (.MCLK(MCLK), .RST_B(RST_B), .MODE_WE(MODE_WE),
	.MODE_WDATA(MODE_WDATA), .RUN_BIT_A(RUN_BIT_A), .RUN_BIT_B(RUN_BIT_B), .CNT_WE(CNT_WE),
	.IRQ_ACK(IRQ_ACK), .OVERFLOW_IRQ_EN_A(OVERFLOW_IRQ_EN_A),
	.GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .TIMER_MODE_REG(TIMER_MODE_REG),
	.COUNT_LOW_B(COUNT_LOW_B), .COUNT_HIGH_B(COUNT_HIGH_B), .OVERFLOW_FLAG_A(OVERFLOW_FLAG_A),
	.OVERFLOW_FLAG_B(OVERFLOW_FLAG_B), .IRQ_REQ(IRQ_REQ), .IRQ_VEC(IRQ_VEC));
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: Directed bench for dtc_top
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Six-clock mode after the first 12-clock tick check keeps waits short
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic	MCLK, RST_B, SIX_CLK_MODE, MODE_WE, RUN_BIT_A, RUN_BIT_B, CNT_WE;
	logic	FLAG_CLR_A, FLAG_CLR_B, IRQ_ACK, OVERFLOW_IRQ_EN_A, OVERFLOW_IRQ_EN_B;
	logic	GLOBAL_IRQ_ENABLE, EXT_IRQ_PIN_A, EXT_IRQ_PIN_B, CNT_PIN_A, CNT_PIN_B;
	logic	OVERFLOW_FLAG_A, OVERFLOW_FLAG_B, IRQ_REQ;
	logic [1:0]	CNT_SEL;
	logic [7:0]	MODE_WDATA, CNT_WDATA, TIMER_MODE_REG, COUNT_LOW_A, COUNT_HIGH_A;
	logic [7:0]	COUNT_LOW_B, COUNT_HIGH_B;
	logic [15:0]	IRQ_VEC, cb, v;
	int	error_cnt, n_checks, i;
	assign cb = {COUNT_HIGH_B, COUNT_LOW_B};
	dtc_top i_dtc_top (.MCLK(MCLK), .RST_B(RST_B), .SIX_CLK_MODE(SIX_CLK_MODE),
		.MODE_WE(MODE_WE), .MODE_WDATA(MODE_WDATA), .RUN_BIT_A(RUN_BIT_A),
		.RUN_BIT_B(RUN_BIT_B), .CNT_WE(CNT_WE), .CNT_SEL(CNT_SEL), .CNT_WDATA(CNT_WDATA),
		.FLAG_CLR_A(FLAG_CLR_A), .FLAG_CLR_B(FLAG_CLR_B), .IRQ_ACK(IRQ_ACK),
		.OVERFLOW_IRQ_EN_A(OVERFLOW_IRQ_EN_A), .OVERFLOW_IRQ_EN_B(OVERFLOW_IRQ_EN_B),
		.GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .EXT_IRQ_PIN_A(EXT_IRQ_PIN_A),
		.EXT_IRQ_PIN_B(EXT_IRQ_PIN_B), .CNT_PIN_A(CNT_PIN_A), .CNT_PIN_B(CNT_PIN_B),
		.TIMER_MODE_REG(TIMER_MODE_REG), .COUNT_LOW_A(COUNT_LOW_A),
		.COUNT_HIGH_A(COUNT_HIGH_A), .COUNT_LOW_B(COUNT_LOW_B), .COUNT_HIGH_B(COUNT_HIGH_B),
		.OVERFLOW_FLAG_A(OVERFLOW_FLAG_A), .OVERFLOW_FLAG_B(OVERFLOW_FLAG_B),
		.IRQ_REQ(IRQ_REQ), .IRQ_VEC(IRQ_VEC));
	initial begin
		MCLK = 1'b0;
		forever #20 MCLK = ~MCLK;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge MCLK);
		#1;
	endtask : cyc
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	task automatic tmo;
		error_cnt++;
		$display("mismatch at %0t: wait timed out", $time);
		end_of_test();
	endtask : tmo
	task automatic wflag(input logic b);
		for (i = 0; i < 40 && (b ? OVERFLOW_FLAG_B : OVERFLOW_FLAG_A) !== 1'b1; i++)
			cyc(1);
		if (i == 40)
			tmo();
	endtask : wflag
	// Syncs to the first increment, then times the next one exactly
	task automatic tick(input int n);
		v = cb;
		for (i = 0; i < 30 && cb === v; i++)
			cyc(1);
		if (i == 30)
			tmo();
		v = cb;
		cyc(n - 1);
		chk(cb, v);
		cyc(1);
		chk(cb, v + 16'h1);
	endtask : tick
	// Strobe tasks let a spare edge pass so back-to-back calls never retoggle in one step
	task automatic wm(input logic [7:0] d);
		MODE_WDATA = d;
		MODE_WE = 1'b1;
		cyc(1);
		MODE_WE = 1'b0;
		chk(TIMER_MODE_REG, d);
		cyc(1);
	endtask : wm
	task automatic wc(input logic [1:0] s, input logic [7:0] d);
		CNT_SEL = s;
		CNT_WDATA = d;
		CNT_WE = 1'b1;
		cyc(1);
		CNT_WE = 1'b0;
		cyc(1);
	endtask : wc
	task automatic tend(input string s);
		$display("test %s done", s);
	endtask : tend
	initial begin
		{RST_B, SIX_CLK_MODE, MODE_WE, RUN_BIT_A, RUN_BIT_B, CNT_WE, FLAG_CLR_A} = '0;
		{FLAG_CLR_B, IRQ_ACK, OVERFLOW_IRQ_EN_A, OVERFLOW_IRQ_EN_B, GLOBAL_IRQ_ENABLE} = '0;
		{EXT_IRQ_PIN_A, EXT_IRQ_PIN_B, CNT_PIN_A, CNT_PIN_B, CNT_SEL} = '0;
		{MODE_WDATA, CNT_WDATA} = '0;
		error_cnt = 0;
		n_checks = 0;
		cyc(3);
		RST_B = 1'b1;
		wm(8'h10);
		RUN_BIT_B = 1'b1;
		tick(12);
		SIX_CLK_MODE = 1'b1;
		tick(6);
		RUN_BIT_B = 1'b0;
		wc(2'h2, 8'hfe);
		wc(2'h3, 8'hff);
		// Let a machine-cycle tick pass so a stopped timer is really tested
		cyc(6);
		chk(cb, 16'hfffe);
		RUN_BIT_B = 1'b1;
		wflag(1'b1);
		chk(cb, 16'h0000);
		RUN_BIT_B = 1'b0;
		FLAG_CLR_B = 1'b1;
		cyc(1);
		FLAG_CLR_B = 1'b0;
		wm(8'h00);
		wc(2'h2, 8'hff);
		wc(2'h3, 8'hff);
		RUN_BIT_B = 1'b1;
		wflag(1'b1);
		chk(cb, 16'h00e0);
		RUN_BIT_B = 1'b0;
		FLAG_CLR_B = 1'b1;
		cyc(1);
		FLAG_CLR_B = 1'b0;
		wm(8'h80);
		RUN_BIT_B = 1'b1;
		v = cb;
		cyc(30);
		chk(cb, v);
		EXT_IRQ_PIN_B = 1'b1;
		tick(6);
		wm(8'h30);
		v = cb;
		cyc(30);
		chk(cb, v);
		tend("timer_b");
		wm(8'h50);
		v = cb;
		repeat (3) begin
			CNT_PIN_B = 1'b1;
			cyc(1);
			CNT_PIN_B = 1'b0;
			cyc(1);
		end
		CNT_PIN_B = 1'b1;
		cyc(5);
		chk(cb, v + 16'h3);
		RUN_BIT_B = 1'b0;
		wm(8'h03);
		wc(2'h0, 8'hff);
		wc(2'h1, 8'hfe);
		// B wraps on the first tick, A high byte only on the second
		wc(2'h2, 8'h1f);
		wc(2'h3, 8'hff);
		RUN_BIT_B = 1'b1;
		wflag(1'b1);
		chk(cb, 16'h0001);
		chk({COUNT_HIGH_A, COUNT_LOW_A}, 16'h00ff);
		chk(OVERFLOW_FLAG_A, 1'b0);
		RUN_BIT_B = 1'b0;
		RUN_BIT_A = 1'b1;
		wflag(1'b0);
		chk({COUNT_HIGH_A, COUNT_LOW_A}, 16'h0000);
		RUN_BIT_A = 1'b0;
		tend("split");
		wm(8'h06);
		wc(2'h1, 8'hfd);
		wc(2'h0, 8'hff);
		FLAG_CLR_A = 1'b1;
		cyc(1);
		FLAG_CLR_A = 1'b0;
		OVERFLOW_IRQ_EN_A = 1'b1;
		RUN_BIT_A = 1'b1;
		CNT_PIN_A = 1'b1;
		cyc(1);
		CNT_PIN_A = 1'b0;
		cyc(1);
		chk({COUNT_HIGH_A, COUNT_LOW_A}, 16'hfdfd);
		chk(OVERFLOW_FLAG_A, 16'h0001);
		chk(IRQ_REQ, 1'b0);
		GLOBAL_IRQ_ENABLE = 1'b1;
		cyc(1);
		chk(IRQ_REQ, 16'h0001);
		chk(IRQ_VEC, 16'h000b);
		RUN_BIT_A = 1'b0;
		IRQ_ACK = 1'b1;
		cyc(1);
		IRQ_ACK = 1'b0;
		chk({OVERFLOW_FLAG_A, IRQ_REQ}, 2'h0);
		tend("reload_irq");
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
